/* design/ncv_pkg.sv */
package ncv_pkg;
  // command codes
  localparam logic [7:0] CMD_VERIFY_ALL = 8'h01;
  localparam logic [7:0] CMD_VERIFY_BLOCK = 8'h02;
  localparam logic [7:0] CMD_VERIFY_PSECT = 8'h03;
  localparam logic [7:0] CMD_READ_ONCE = 8'h04;
  localparam logic [7:0] CMD_PROG_PFLASH = 8'h06;
  localparam logic [7:0] CMD_PROG_ONCE = 8'h07;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
  localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
  localparam logic [7:0] CMD_ERASE_PSECTOR = 8'h0A;
  localparam logic [7:0] CMD_RELEASE_ERASE = 8'h0B;
  localparam logic [7:0] CMD_KEY_RELEASE = 8'h0C;
  localparam logic [7:0] CMD_USER_MARGIN = 8'h0D;
  localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0E;
  localparam logic [7:0] CMD_VERIFY_ESECT = 8'h10;
  localparam logic [7:0] CMD_PROG_EEPROM = 8'h11;
  localparam logic [7:0] CMD_ERASE_ESECTOR = 8'h12;
  localparam logic [7:0] CMD_PROT_OVERRIDE = 8'h13;

  // one-time field geometry
  localparam int ONCE_FIELD_BYTES = 64;
  localparam int ONCE_PHRASE_BYTES = 8;
  localparam int ONCE_PARTS = ONCE_FIELD_BYTES / ONCE_PHRASE_BYTES;
  localparam int ONCE_IDX_W = $clog2(ONCE_PARTS);
  localparam int ONCE_IDX_LSB = $clog2(ONCE_PHRASE_BYTES);

  // eeprom program word count limits
  localparam logic [2:0] EE_WORDS_MIN = 3'h1;
  localparam logic [2:0] EE_WORDS_MAX = 3'h4;

  // reset values
  localparam logic [ONCE_PARTS-1:0] ONCE_USED_RST = '0;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_VERIFY_ALL,
    OP_VERIFY_BLOCK,
    OP_VERIFY_PSECT,
    OP_VERIFY_ESECT,
    OP_READ_ONCE,
    OP_PROG_PFLASH,
    OP_PROG_ONCE,
    OP_ERASE_ALL,
    OP_ERASE_BLOCK,
    OP_ERASE_PSECTOR,
    OP_PROG_EEPROM,
    OP_ERASE_ESECTOR
  } ncv_op_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARRAY,
    ST_LOCAL
  } ncv_state_e;
endpackage

/* design/ncv_command_validator.sv */
// Functional notes
// - acceptance comes from a fixed per-code table of mode and security state
// - secured special mode accepts only 0x01, 0x02, 0x0B and 0x13
// - 0x0B accepted only in special mode, secured or not
// - 0x01 verifies all blocks erased and reports the result at completion
// - 0x02 verifies the addressed pflash or eeprom block is erased
// - 0x03 and 0x10 verify a counted word range in pflash or eeprom
// - 0x04 reads the 64-byte one-time field
// - 0x07 programs the one-time field, each part only once
// - 0x06 programs one phrase at the given pflash address
// - 0x08 erases everything only with all four protection-open bits set
// - 0x09 on pflash needs low, high disable and open bits set
// - 0x09 on eeprom needs the eeprom open bit set
// - 0x0A erases the addressed pflash sector
// - 0x0B erases all blocks, verifies them, then releases security only if the verify finds them erased
// - 0x0C releases security only on matching keys
// - 0x0D sets the user margin level for pflash or eeprom
// - 0x0E sets field margin level, unsecured special mode only
// - 0x11 programs one to four eeprom words
// - 0x12 erases the addressed eeprom sector
// - 0x13 overrides protection only after key verification
// - invalid code sets access error and is not processed
// - accepted launch clears complete flag; it is set again when the command ends
// - program or erase refused with access error before divider is written
`timescale 1ns/1ps
module ncv_command_validator #(
  parameter int ADDR_W = 24,
  parameter int COUNT_W = 16,
  parameter int DATA_W = 16,
  parameter int KEY_W = 64,
  parameter int MARGIN_W = 16
) (
  // clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // chip state
  input wire logic special_mode_in,
  input wire logic secured_in,
  // command side
  input wire logic cmd_launch_in,
  input wire logic [7:0] nvm_command_code_in,
  input wire logic [ADDR_W-1:0] cmd_addr_in,
  input wire logic [COUNT_W-1:0] cmd_count_in,
  input wire logic [DATA_W-1:0] cmd_data_in,
  input wire logic [KEY_W-1:0] cmd_key_in,
  input wire logic target_eeprom_in,
  input wire logic divider_write_in,
  input wire logic access_error_clear_in,
  input wire logic protection_violation_clear_in,
  // protection configuration
  input wire logic pflash_low_region_disable_in,
  input wire logic pflash_high_region_disable_in,
  input wire logic pflash_open_protection_in,
  input wire logic eeprom_open_protection_in,
  input wire logic [KEY_W-1:0] stored_key_in,
  // array side
  input wire logic array_done_in,
  input wire logic array_erased_in,
  output ncv_pkg::ncv_op_e array_op_out,
  output logic array_start_out,
  output logic array_target_eeprom_out,
  output logic [ADDR_W-1:0] array_addr_out,
  output logic [COUNT_W-1:0] array_count_out,
  output logic [DATA_W-1:0] array_data_out,
  // status
  output logic command_complete_flag_out,
  output logic access_error_flag_out,
  output logic protection_violation_flag_out,
  output logic verify_fail_out,
  output logic divider_loaded_out,
  output logic security_release_out,
  output logic [MARGIN_W-1:0] user_margin_pflash_out,
  output logic [MARGIN_W-1:0] user_margin_eeprom_out,
  output logic [MARGIN_W-1:0] field_margin_pflash_out,
  output logic [MARGIN_W-1:0] field_margin_eeprom_out,
  output logic override_active_out,
  output logic override_target_eeprom_out,
  output logic [DATA_W-1:0] override_protection_out
);
  import ncv_pkg::*;

  typedef struct packed {
    ncv_state_e state;
    logic command_complete_flag;
    logic access_error_flag;
    logic pviol;
    logic verify_fail;
    logic div_loaded;
    logic unsec;
    logic sec_release;
    logic start;
    ncv_op_e op;
    logic tgt_e;
    logic [ADDR_W-1:0] addr;
    logic [COUNT_W-1:0] count;
    logic [DATA_W-1:0] data;
    logic [ONCE_PARTS-1:0] once_used;
    logic [MARGIN_W-1:0] um_p;
    logic [MARGIN_W-1:0] um_e;
    logic [MARGIN_W-1:0] fm_p;
    logic [MARGIN_W-1:0] fm_e;
    logic ovr;
    logic ovr_e;
    logic [DATA_W-1:0] ovr_prot;
  } ncv_regs_s;

  ncv_regs_s st_reg;
  ncv_regs_s st_next;

  // permission per code: ns unsecured, ss unsecured, ns secured, ss secured
  function automatic logic ncv_permitted(input logic [7:0] code, input logic ss, input logic sec);
    logic [3:0] allow;
    allow = 4'h0;
    case (code)
      CMD_VERIFY_ALL, CMD_VERIFY_BLOCK, CMD_PROT_OVERRIDE: allow = 4'hF;
      CMD_VERIFY_PSECT, CMD_READ_ONCE, CMD_PROG_PFLASH, CMD_PROG_ONCE,
      CMD_ERASE_BLOCK, CMD_ERASE_PSECTOR, CMD_USER_MARGIN, CMD_VERIFY_ESECT,
      CMD_PROG_EEPROM, CMD_ERASE_ESECTOR: allow = 4'h7;
      CMD_ERASE_ALL: allow = 4'h5;
      CMD_RELEASE_ERASE: allow = 4'hA;
      CMD_KEY_RELEASE: allow = 4'h5;
      CMD_FIELD_MARGIN: allow = 4'h2;
      default: allow = 4'h0;
    endcase
    return allow[{sec, ss}];
  endfunction

  // commands that need the program/erase time base
  function automatic logic ncv_prog_erase(input logic [7:0] code);
    case (code)
      CMD_PROG_PFLASH, CMD_PROG_ONCE, CMD_ERASE_ALL, CMD_ERASE_BLOCK,
      CMD_ERASE_PSECTOR, CMD_RELEASE_ERASE, CMD_PROG_EEPROM,
      CMD_ERASE_ESECTOR: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // verify operations report erased state
  function automatic logic ncv_is_verify(input ncv_op_e op);
    return (op == OP_VERIFY_ALL) || (op == OP_VERIFY_BLOCK) ||
           (op == OP_VERIFY_PSECT) || (op == OP_VERIFY_ESECT);
  endfunction

  logic launch_ok;
  logic key_match;
  logic pflash_open_all;
  logic [ONCE_IDX_W-1:0] once_idx;

  // launch only counts while idle with both error flags clear
  assign launch_ok = cmd_launch_in && st_reg.command_complete_flag && !st_reg.access_error_flag && !st_reg.pviol;
  assign key_match = (cmd_key_in == stored_key_in);
  assign pflash_open_all = pflash_low_region_disable_in && pflash_high_region_disable_in &&
                           pflash_open_protection_in;
  assign once_idx = cmd_addr_in[ONCE_IDX_LSB +: ONCE_IDX_W];

  // next-state logic
  always_comb begin
    logic go_array;
    logic go_local;
    logic rej_acc;
    logic rej_prot;
    ncv_op_e op_sel;
    go_array = 1'b0;
    go_local = 1'b0;
    rej_acc = 1'b0;
    rej_prot = 1'b0;
    op_sel = OP_NONE;
    st_next = st_reg;
    st_next.start = 1'b0;
    st_next.sec_release = 1'b0;
    if (divider_write_in) begin
      st_next.div_loaded = 1'b1;
    end
    // clears come first so that a same-cycle set below wins
    if (access_error_clear_in) begin
      st_next.access_error_flag = 1'b0;
    end
    if (protection_violation_clear_in) begin
      st_next.pviol = 1'b0;
    end
    case (st_reg.state)
      ST_IDLE: begin
        if (launch_ok) begin
          if (!ncv_permitted(nvm_command_code_in, special_mode_in, secured_in)) begin
            rej_acc = 1'b1;
          end else if (ncv_prog_erase(nvm_command_code_in) && !st_reg.div_loaded) begin
            rej_acc = 1'b1;
          end else begin
            case (nvm_command_code_in)
              CMD_VERIFY_ALL: begin
                op_sel = OP_VERIFY_ALL;
                go_array = 1'b1;
              end
              CMD_VERIFY_BLOCK: begin
                op_sel = OP_VERIFY_BLOCK;
                go_array = 1'b1;
              end
              CMD_VERIFY_PSECT: begin
                op_sel = OP_VERIFY_PSECT;
                go_array = 1'b1;
              end
              CMD_VERIFY_ESECT: begin
                op_sel = OP_VERIFY_ESECT;
                go_array = 1'b1;
              end
              CMD_READ_ONCE: begin
                op_sel = OP_READ_ONCE;
                go_array = 1'b1;
              end
              CMD_PROG_ONCE: begin
                if (st_reg.once_used[once_idx]) begin
                  rej_acc = 1'b1;
                end else begin
                  op_sel = OP_PROG_ONCE;
                  go_array = 1'b1;
                  st_next.once_used[once_idx] = 1'b1;
                end
              end
              CMD_PROG_PFLASH: begin
                op_sel = OP_PROG_PFLASH;
                go_array = 1'b1;
              end
              CMD_ERASE_ALL: begin
                if (pflash_open_all && eeprom_open_protection_in) begin
                  op_sel = OP_ERASE_ALL;
                  go_array = 1'b1;
                end else begin
                  rej_prot = 1'b1;
                end
              end
              CMD_ERASE_BLOCK: begin
                if (target_eeprom_in ? eeprom_open_protection_in : pflash_open_all) begin
                  op_sel = OP_ERASE_BLOCK;
                  go_array = 1'b1;
                end else begin
                  rej_prot = 1'b1;
                end
              end
              CMD_ERASE_PSECTOR: begin
                op_sel = OP_ERASE_PSECTOR;
                go_array = 1'b1;
              end
              CMD_RELEASE_ERASE: begin
                op_sel = OP_ERASE_ALL;
                go_array = 1'b1;
                st_next.unsec = 1'b1;
              end
              CMD_KEY_RELEASE: begin
                if (key_match) begin
                  st_next.sec_release = 1'b1;
                  go_local = 1'b1;
                end else begin
                  rej_acc = 1'b1;
                end
              end
              CMD_USER_MARGIN: begin
                go_local = 1'b1;
                if (target_eeprom_in) begin
                  st_next.um_e = cmd_data_in[MARGIN_W-1:0];
                end else begin
                  st_next.um_p = cmd_data_in[MARGIN_W-1:0];
                end
              end
              CMD_FIELD_MARGIN: begin
                go_local = 1'b1;
                if (target_eeprom_in) begin
                  st_next.fm_e = cmd_data_in[MARGIN_W-1:0];
                end else begin
                  st_next.fm_p = cmd_data_in[MARGIN_W-1:0];
                end
              end
              CMD_PROG_EEPROM: begin
                if ((cmd_count_in < COUNT_W'(EE_WORDS_MIN)) || (cmd_count_in > COUNT_W'(EE_WORDS_MAX))) begin
                  rej_acc = 1'b1;
                end else begin
                  op_sel = OP_PROG_EEPROM;
                  go_array = 1'b1;
                end
              end
              CMD_ERASE_ESECTOR: begin
                op_sel = OP_ERASE_ESECTOR;
                go_array = 1'b1;
              end
              CMD_PROT_OVERRIDE: begin
                if (key_match) begin
                  st_next.ovr = 1'b1;
                  st_next.ovr_e = target_eeprom_in;
                  st_next.ovr_prot = cmd_data_in;
                  go_local = 1'b1;
                end else begin
                  rej_acc = 1'b1;
                end
              end
              default: rej_acc = 1'b1;
            endcase
          end
          // rejected commands leave the array alone and complete flag set
          if (rej_acc) begin
            st_next.access_error_flag = 1'b1;
          end
          if (rej_prot) begin
            st_next.pviol = 1'b1;
          end
          if (go_array) begin
            st_next.command_complete_flag = 1'b0;
            st_next.state = ST_ARRAY;
            st_next.start = 1'b1;
            st_next.op = op_sel;
            st_next.verify_fail = 1'b0;
            st_next.tgt_e = target_eeprom_in;
            st_next.addr = cmd_addr_in;
            st_next.count = cmd_count_in;
            st_next.data = cmd_data_in;
          end else if (go_local) begin
            st_next.command_complete_flag = 1'b0;
            st_next.state = ST_LOCAL;
          end
        end
      end
      ST_ARRAY: begin
        if (array_done_in) begin
          if (st_reg.unsec && (st_reg.op == OP_ERASE_ALL)) begin
            // erase phase done, the confirming blank check follows
            st_next.op = OP_VERIFY_ALL;
            st_next.start = 1'b1;
          end else begin
            if (ncv_is_verify(st_reg.op) && !array_erased_in) begin
              st_next.verify_fail = 1'b1;
            end
            if (st_reg.unsec && array_erased_in) begin
              st_next.sec_release = 1'b1;
            end
            st_next.unsec = 1'b0;
            st_next.command_complete_flag = 1'b1;
            st_next.state = ST_IDLE;
          end
        end
      end
      ST_LOCAL: begin
        // local commands finish one cycle after launch
        st_next.command_complete_flag = 1'b1;
        st_next.state = ST_IDLE;
      end
      default: begin
        st_next.state = ST_IDLE;
        st_next.command_complete_flag = 1'b1;
      end
    endcase
  end

  // state register; clock enable freezes everything except the synchronous reset
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_reg <= '0;
      st_reg.state <= ST_IDLE;
      st_reg.command_complete_flag <= 1'b1;
      st_reg.op <= OP_NONE;
      st_reg.once_used <= ONCE_USED_RST;
    end else if (clk_en_in) begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign array_op_out = st_reg.op;
  assign array_start_out = st_reg.start;
  assign array_target_eeprom_out = st_reg.tgt_e;
  assign array_addr_out = st_reg.addr;
  assign array_count_out = st_reg.count;
  assign array_data_out = st_reg.data;
  assign command_complete_flag_out = st_reg.command_complete_flag;
  assign access_error_flag_out = st_reg.access_error_flag;
  assign protection_violation_flag_out = st_reg.pviol;
  assign verify_fail_out = st_reg.verify_fail;
  assign divider_loaded_out = st_reg.div_loaded;
  assign security_release_out = st_reg.sec_release;
  assign user_margin_pflash_out = st_reg.um_p;
  assign user_margin_eeprom_out = st_reg.um_e;
  assign field_margin_pflash_out = st_reg.fm_p;
  assign field_margin_eeprom_out = st_reg.fm_e;
  assign override_active_out = st_reg.ovr;
  assign override_target_eeprom_out = st_reg.ovr_e;
  assign override_protection_out = st_reg.ovr_prot;
endmodule

/* bench/ncv_command_validator_monitor.sv */
`timescale 1ns/1ps
module ncv_command_validator_monitor (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // command side
  input wire logic clk_en_in,
  input wire logic special_mode_in,
  input wire logic secured_in,
  input wire logic cmd_launch_in,
  input wire logic [7:0] nvm_command_code_in,
  input wire logic target_eeprom_in,
  input wire logic pflash_low_region_disable_in,
  input wire logic pflash_high_region_disable_in,
  input wire logic pflash_open_protection_in,
  input wire logic eeprom_open_protection_in,
  input wire logic array_done_in,
  // outputs watched
  input wire ncv_pkg::ncv_op_e array_op_out,
  input wire logic array_start_out,
  input wire logic command_complete_flag_out,
  input wire logic access_error_flag_out,
  input wire logic protection_violation_flag_out,
  input wire logic divider_loaded_out,
  input wire logic security_release_out
);
  import ncv_pkg::*;
  logic taken;
  logic pf_open;
  // a launch the block has to act on; ignored launches stay out of every antecedent
  assign taken = clk_en_in && cmd_launch_in && command_complete_flag_out && !access_error_flag_out
    && !protection_violation_flag_out;
  assign pf_open = pflash_low_region_disable_in && pflash_high_region_disable_in && pflash_open_protection_in;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_refused;
    access_error_flag_out && !array_start_out && command_complete_flag_out;
  endsequence
  sequence s_local;
    !command_complete_flag_out ##1 command_complete_flag_out;
  endsequence
  property p_secured_special;
    taken && special_mode_in && secured_in && !(nvm_command_code_in inside {8'h01, 8'h02, 8'h0B, 8'h13})
      |=> s_refused;
  endproperty
  a_secured_special: assert property (p_secured_special)
    else $error("secured special launch not refused");
  property p_release_normal;
    taken && nvm_command_code_in == 8'h0B && !special_mode_in |=> s_refused;
  endproperty
  a_release_normal: assert property (p_release_normal)
    else $error("release by erase accepted in normal mode");
  property p_no_divider;
    taken && !divider_loaded_out && nvm_command_code_in inside {8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h11, 8'h12}
      |=> s_refused;
  endproperty
  a_no_divider: assert property (p_no_divider)
    else $error("program or erase ran without divider");
  property p_invalid;
    taken && !(nvm_command_code_in inside {[8'h01:8'h04], [8'h06:8'h0E], [8'h10:8'h13]}) |=> s_refused;
  endproperty
  a_invalid: assert property (p_invalid)
    else $error("invalid code not refused");
  property p_erase_all_prot;
    taken && nvm_command_code_in == 8'h08 && !special_mode_in && divider_loaded_out
      && !(pf_open && eeprom_open_protection_in) |=> protection_violation_flag_out && !array_start_out;
  endproperty
  a_erase_all_prot: assert property (p_erase_all_prot)
    else $error("erase all ran with protection closed");
  property p_block_prot;
    taken && nvm_command_code_in == 8'h09 && !special_mode_in && divider_loaded_out
      && (target_eeprom_in ? !eeprom_open_protection_in : !pf_open) |=> protection_violation_flag_out && !array_start_out;
  endproperty
  a_block_prot: assert property (p_block_prot)
    else $error("block erase ran with protection closed");
  property p_start_cause;
    array_start_out |-> !command_complete_flag_out && ($past(taken) || $past(array_done_in) && array_op_out == OP_VERIFY_ALL);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("array started without accepted launch");
  property p_local_margin;
    taken && nvm_command_code_in == 8'h0D && !(special_mode_in && secured_in) |=> s_local;
  endproperty
  a_local_margin: assert property (p_local_margin)
    else $error("margin command did not complete in two cycles");
  property p_release_pulse;
    security_release_out |-> (command_complete_flag_out && $past(array_done_in) && $past(array_op_out) == OP_VERIFY_ALL)
      || (!command_complete_flag_out && $past(taken) && $past(nvm_command_code_in) == 8'h0C);
  endproperty
  a_release_pulse: assert property (p_release_pulse)
    else $error("security release without final verify");
  property p_done_completes;
    array_done_in && !command_complete_flag_out && array_op_out == OP_PROG_PFLASH |=> command_complete_flag_out;
  endproperty
  a_done_completes: assert property (p_done_completes)
    else $error("complete flag not set after array done");
endmodule
bind ncv_command_validator ncv_command_validator_monitor i_monitor (.ref_clk_in, .rst_in, .clk_en_in,
  .special_mode_in, .secured_in, .cmd_launch_in, .nvm_command_code_in, .target_eeprom_in,
  .pflash_low_region_disable_in, .pflash_high_region_disable_in, .pflash_open_protection_in,
  .eeprom_open_protection_in, .array_done_in, .array_op_out, .array_start_out, .command_complete_flag_out,
  .access_error_flag_out, .protection_violation_flag_out, .divider_loaded_out, .security_release_out);

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import ncv_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic special_mode_in = 1'b0, secured_in = 1'b0, cmd_launch_in = 1'b0, target_eeprom_in = 1'b0;
  logic divider_write_in = 1'b0, access_error_clear_in = 1'b0, protection_violation_clear_in = 1'b0;
  logic pflash_low_region_disable_in = 1'b1, pflash_high_region_disable_in = 1'b1;
  logic pflash_open_protection_in = 1'b1, eeprom_open_protection_in = 1'b1;
  logic array_done_in = 1'b0, array_erased_in = 1'b0;
  logic [7:0] nvm_command_code_in = 8'h00;
  logic [23:0] cmd_addr_in = 24'h000000;
  logic [15:0] cmd_count_in = 16'h0004, cmd_data_in = 16'h0005;
  logic [63:0] cmd_key_in = 64'h0123456789ABCDEF, stored_key_in = 64'h0123456789ABCDEF;
  ncv_op_e array_op_out;
  logic array_start_out, command_complete_flag_out, access_error_flag_out, protection_violation_flag_out;
  logic verify_fail_out, divider_loaded_out, security_release_out, override_active_out;
  logic [15:0] user_margin_pflash_out, field_margin_pflash_out, override_protection_out;
  int failures = 0, total_checks = 0;
  logic [7:0] codes [19] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B,
    8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12, 8'h13, 8'h05, 8'hFF};

  ncv_command_validator i_dut (.ref_clk_in, .rst_in, .clk_en_in, .special_mode_in, .secured_in,
    .cmd_launch_in, .nvm_command_code_in, .cmd_addr_in, .cmd_count_in, .cmd_data_in, .cmd_key_in,
    .target_eeprom_in, .divider_write_in, .access_error_clear_in, .protection_violation_clear_in,
    .pflash_low_region_disable_in, .pflash_high_region_disable_in, .pflash_open_protection_in,
    .eeprom_open_protection_in, .stored_key_in, .array_done_in, .array_erased_in, .array_op_out,
    .array_start_out, .array_target_eeprom_out(), .array_addr_out(), .array_count_out(), .array_data_out(),
    .command_complete_flag_out, .access_error_flag_out, .protection_violation_flag_out, .verify_fail_out,
    .divider_loaded_out, .security_release_out, .user_margin_pflash_out, .user_margin_eeprom_out(),
    .field_margin_pflash_out, .field_margin_eeprom_out(), .override_active_out,
    .override_target_eeprom_out(), .override_protection_out);

  // free-running bus clock
  always #5 ref_clk_in = ~ref_clk_in;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // 0 divider write, 1 access error clear, 2 violation clear
  task automatic strobe(input int w);
    @(posedge ref_clk_in);
    case (w)
      0: divider_write_in <= 1'b1;
      1: access_error_clear_in <= 1'b1;
      default: protection_violation_clear_in <= 1'b1;
    endcase
    @(posedge ref_clk_in);
    {divider_write_in, access_error_clear_in, protection_violation_clear_in} <= 3'b000;
  endtask

  // one array done pulse, sampled one cycle later
  task automatic complete_op(input logic ok);
    repeat (2) @(posedge ref_clk_in);
    array_done_in <= 1'b1;
    array_erased_in <= ok;
    @(posedge ref_clk_in);
    array_done_in <= 1'b0;
    #1;
  endtask

  // outcome: 0 access error, 1 array, 2 local, 3 protection violation
  function automatic int outcome(input logic [7:0] c, input logic sp, input logic sc);
    case (c)
      8'h01, 8'h02: return 1;
      8'h13: return 2;
      8'h0B: return sp ? 1 : 0;
      8'h08: return sp ? 0 : 1;
      8'h0C: return sp ? 0 : 2;
      8'h0E: return (sp && !sc) ? 2 : 0;
      8'h0D: return (sp && sc) ? 0 : 2;
      8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h10, 8'h11, 8'h12: return (sp && sc) ? 0 : 1;
      default: return 0;
    endcase
  endfunction

  function automatic ncv_op_e op_of(input logic [7:0] c);
    case (c)
      8'h01: return OP_VERIFY_ALL;
      8'h02: return OP_VERIFY_BLOCK;
      8'h03: return OP_VERIFY_PSECT;
      8'h10: return OP_VERIFY_ESECT;
      8'h04: return OP_READ_ONCE;
      8'h06: return OP_PROG_PFLASH;
      8'h07: return OP_PROG_ONCE;
      8'h08, 8'h0B: return OP_ERASE_ALL;
      8'h09: return OP_ERASE_BLOCK;
      8'h0A: return OP_ERASE_PSECTOR;
      8'h11: return OP_PROG_EEPROM;
      8'h12: return OP_ERASE_ESECTOR;
      default: return OP_NONE;
    endcase
  endfunction

  // launch one command and follow it to its end
  task automatic run(input logic [7:0] c, input int k);
    @(posedge ref_clk_in);
    cmd_launch_in <= 1'b1;
    nvm_command_code_in <= c;
    @(posedge ref_clk_in);
    cmd_launch_in <= 1'b0;
    #1;
    check(command_complete_flag_out, k == 0 || k == 3);
    check(array_start_out, k == 1);
    check(access_error_flag_out, k == 0);
    check(protection_violation_flag_out, k == 3);
    if (k == 1) begin
      check(array_op_out, op_of(c));
      complete_op(1'b1);
      if (c == 8'h0B) begin
        check(array_op_out, OP_VERIFY_ALL);
        complete_op(1'b1);
        check(security_release_out, 1'b1);
      end
      check(command_complete_flag_out, 1'b1);
    end else if (k == 2) begin
      @(posedge ref_clk_in);
      #1;
      check(command_complete_flag_out, 1'b1);
    end else begin
      strobe(k == 0 ? 1 : 2);
    end
  endtask

  initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    #1;
    check(command_complete_flag_out, 1'b1);
    check(array_op_out, OP_NONE);
    run(8'h06, 0);
    run(8'h01, 1);
    strobe(0);
    $display("finished divider test");
    // every code in every mode and security state
    for (int m = 0; m < 4; m++) begin
      @(posedge ref_clk_in);
      {special_mode_in, secured_in} <= 2'(m);
      cmd_addr_in <= 24'(m * 8);
      for (int i = 0; i < 19; i++) begin
        run(codes[i], outcome(codes[i], m[1], m[0]));
      end
    end
    check(user_margin_pflash_out, 16'h0005);
    check(field_margin_pflash_out, 16'h0005);
    check(override_active_out, 1'b1);
    check(override_protection_out, 16'h0005);
    $display("finished mode table test");
    @(posedge ref_clk_in);
    {special_mode_in, secured_in} <= 2'b00;
    cmd_addr_in <= 24'h000000;
    run(8'h07, 0);
    @(posedge ref_clk_in);
    cmd_addr_in <= 24'h000038;
    run(8'h07, 1);
    cmd_count_in <= 16'h0005;
    run(8'h11, 0);
    cmd_count_in <= 16'h0001;
    run(8'h11, 1);
    cmd_key_in <= 64'h0;
    run(8'h0C, 0);
    run(8'h13, 0);
    $display("finished parameter test");
    pflash_open_protection_in <= 1'b0;
    run(8'h08, 3);
    run(8'h09, 3);
    target_eeprom_in <= 1'b1;
    run(8'h09, 1);
    eeprom_open_protection_in <= 1'b0;
    run(8'h09, 3);
    $display("finished protection test");
    run(8'h01, 1);
    @(posedge ref_clk_in);
    cmd_launch_in <= 1'b1;
    nvm_command_code_in <= 8'h01;
    @(posedge ref_clk_in);
    cmd_launch_in <= 1'b0;
    complete_op(1'b0);
    check(verify_fail_out, 1'b1);
    $display("finished verify test");
    give_verdict();
  end

  // guards against a hang well beyond the expected few hundred cycles
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
endmodule
